// ===== rtl/smlm_map.vh
// Purpose: constants for the static memory lane mapper
// Assumes: 250 MHz clock, per-select settings arrive as plain ports
// Notes: widths and timing fields are in whole clock cycles
`ifndef SMLM_MAP_VH
`define SMLM_MAP_VH
`define SMLM_NUM_CS 8
`define SMLM_ADDR_W 26
`define SMLM_DATA_W 32
`define SMLM_TW 6
// bus width field encoding
`define SMLM_DBW_8 2'h0
`define SMLM_DBW_16 2'h1
`define SMLM_DBW_32 2'h2
// byte access type encoding
`define SMLM_BAT_SELECT 1'h0
`define SMLM_BAT_WRITE 1'h1
// boot select defaults: byte select, 16-bit
`define SMLM_BOOT_DBW 2'h1
`define SMLM_BOOT_BAT 1'h0
// slow clock mode fixed waveform (cycles)
`define SMLM_SLOW_SETUP 6'h01
`define SMLM_SLOW_PULSE 6'h04
`define SMLM_SLOW_CYCLE 6'h07
// largest page burst, in extra beats
`define SMLM_PAGE_MAX 6'h20
`endif

// ===== rtl/smlm_lane_decode.v
// Purpose: pin function multiplexing by width and access type
// Assumes: lane enables already decoded, strobes active high in
// Notes: purely combinational
`include "smlm_map.vh"
module smlm_lane_decode (
  input wire [1:0] width_in,
  input wire bat_in,
  input wire [3:0] lane_en_in,
  input wire [1:0] addr_lo_in,
  input wire addr_phase_in,
  input wire rd_act_in,
  input wire wr_act_in,
  output reg pin0_out,
  output reg pin1_out,
  output reg pin2_out,
  output reg pin3_out,
  output reg pin4_out,
  output reg rd_n_out
);
  wire bs_mode;
  assign bs_mode = (width_in != `SMLM_DBW_8) && (bat_in == `SMLM_BAT_SELECT);
  always @* begin
    rd_n_out = ~rd_act_in;
    pin0_out = 1'b1;
    pin1_out = ~wr_act_in;
    pin2_out = 1'b1;
    pin3_out = 1'b1;
    pin4_out = 1'b1;
    if (width_in == `SMLM_DBW_8) begin
      pin0_out = addr_lo_in[0];
      pin2_out = addr_lo_in[1];
    end else if (bs_mode) begin
      // lane selects follow address timing
      pin0_out = ~(addr_phase_in & lane_en_in[0]);
      pin2_out = 1'b1;
      pin3_out = ~(addr_phase_in & lane_en_in[1]);
      if (width_in == `SMLM_DBW_32) begin
        pin2_out = ~(addr_phase_in & lane_en_in[2]);
        pin4_out = ~(addr_phase_in & lane_en_in[3]);
      end else begin
        pin2_out = addr_lo_in[1];
      end
    end else begin
      // byte write: one strobe per lane, lane selects unused
      pin1_out = ~(wr_act_in & lane_en_in[0]);
      pin3_out = ~(wr_act_in & lane_en_in[1]);
      if (width_in == `SMLM_DBW_32) begin
        pin2_out = ~(wr_act_in & lane_en_in[2]);
        pin4_out = ~(wr_act_in & lane_en_in[3]);
      end else begin
        pin2_out = addr_lo_in[1];
      end
    end
  end
endmodule // smlm_lane_decode

// ===== rtl/smlm_phase_timer.v
// Purpose: setup / pulse window decode of the access count for one strobe
// Assumes: pulse at least one cycle
// Notes: active while count lies in [setup, setup+pulse)
`include "smlm_map.vh"
module smlm_phase_timer (
  input wire [`SMLM_TW-1:0] count_in,
  input wire [`SMLM_TW-1:0] setup_in,
  input wire [`SMLM_TW-1:0] pulse_in,
  output wire active_out,
  output wire last_out
);
  wire [`SMLM_TW:0] end_w;
  assign end_w = {1'b0, setup_in} + {1'b0, pulse_in};
  assign active_out = ({1'b0, count_in} >= {1'b0, setup_in}) && ({1'b0, count_in} < end_w);
  assign last_out = ({1'b0, count_in} + 7'h01) == end_w;
endmodule // smlm_phase_timer

// ===== rtl/smlm_mapper.v
// Purpose: static memory external interface, pin mapping and access timing
// Assumes: one access request at a time; settings stable during access
// Notes: settings are packed per select, select i in bits of slice i
// Contract
// - eight chip selects, 26-bit address bus
// - per-select width: 8, 16 or 32 bits
// - 64 Mbyte regions, small devices alias
// - significant address lines follow width
// - byte write or byte select per select
// - 16-bit byte write: two write strobes
// - 32-bit byte write: four lane strobes
// - byte select: lane selects, one write enable
// - lane selects ordered low to high byte
// - boot select never uses byte write
// - low address lines unused on wide buses
// - byte select leaves write strobes 1-3 idle
// - byte write leaves lane selects idle
// - shared pins change function with mode
// - wait input stretches current access
// - slow clock mode uses fixed waveforms
// - page-mode burst reads up to 32 extra beats
// - active-low strobes, bidirectional data bus
// - timings per select in whole cycles
// - lane selects timed like the address
`include "smlm_map.vh"
module smlm_mapper (
  input wire clk_in,
  input wire rst_in,
  input wire req_valid_in,
  input wire req_write_in,
  input wire [2:0] req_cs_in,
  input wire [25:0] req_addr_in,
  input wire [1:0] req_size_in,
  input wire [5:0] req_burst_in,
  input wire [31:0] req_wdata_in,
  input wire [15:0] bus_width_field_in,
  input wire [7:0] byte_access_type_in,
  input wire [47:0] rd_setup_in,
  input wire [47:0] rd_pulse_in,
  input wire [47:0] rd_cycle_in,
  input wire [47:0] cs_setup_in,
  input wire [47:0] cs_pulse_in,
  input wire [47:0] wr_setup_in,
  input wire [47:0] wr_pulse_in,
  input wire [47:0] wr_cycle_in,
  input wire slow_clock_in,
  input wire wait_request_n_in,
  input wire [31:0] data_in,
  output wire req_ready_out,
  output reg rsp_valid_out,
  output reg [31:0] rsp_rdata_out,
  output reg [7:0] chip_select_n_out,
  output reg [25:2] addr_out,
  output wire lane0_select_n_out,
  output wire write_enable_n_out,
  output wire lane1_select_n_out,
  output wire lane2_select_n_out,
  output wire lane3_select_n_out,
  output wire read_strobe_n_out,
  output reg [31:0] data_out,
  output reg data_oe_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_NEXT = 2'h2;
  localparam TW = `SMLM_TW;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [TW-1:0] cnt_r;
  reg [2:0] cs_r;
  reg wr_r;
  reg [25:0] addr_r;
  reg [1:0] size_r;
  reg [5:0] beats_r;
  reg [31:0] wdata_r;
  reg [1:0] width_r;
  reg bat_r;
  reg [TW-1:0] rs_r;
  reg [TW-1:0] rp_r;
  reg [TW-1:0] cyc_r;
  reg [TW-1:0] ss_r;
  reg [TW-1:0] sp_r;
  reg [TW-1:0] ws_r;
  reg [TW-1:0] wp_r;
  reg [3:0] lane_en_r;
  reg [1:0] req_width;
  reg req_bat;
  reg [3:0] lane_en_nxt;
  wire strobe_act;
  wire strobe_last;
  wire cs_act;
  wire cs_last;
  wire waiting;
  wire cycle_end;
  wire sample_rd;
  wire [2:0] nbytes;
  wire [7:0] cs_n_nxt;
  // per select configuration, with the boot select forced legal
  genvar gi;
  wire [1:0] w_cfg [0:7];
  wire b_cfg [0:7];
  generate
    for (gi = 0; gi < `SMLM_NUM_CS; gi = gi + 1) begin : g_cfg
      // the unused width code 3 is handled as an 8-bit bus everywhere
      assign w_cfg[gi] = (bus_width_field_in[2*gi+1:2*gi] == 2'h3) ? `SMLM_DBW_8 :
        bus_width_field_in[2*gi+1:2*gi];
      // select 0 may boot: byte write is refused there
      if (gi == 0) begin : g_boot
        assign b_cfg[gi] = `SMLM_BAT_SELECT;
      end else begin : g_norm
        assign b_cfg[gi] = byte_access_type_in[gi];
      end
    end
  endgenerate
  always @* begin
    req_width = w_cfg[req_cs_in];
    req_bat = b_cfg[req_cs_in];
    lane_en_nxt = 4'h0;
    // decode addressed lanes from low address bits and size
    case (req_width)
      `SMLM_DBW_32: begin
        case (req_size_in)
          2'h0: lane_en_nxt = 4'h1 << req_addr_in[1:0];
          2'h1: lane_en_nxt = req_addr_in[1] ? 4'hc : 4'h3;
          default: lane_en_nxt = 4'hf;
        endcase
      end
      `SMLM_DBW_16: begin
        if (req_size_in == 2'h0) begin
          lane_en_nxt = req_addr_in[0] ? 4'h2 : 4'h1;
        end else begin
          lane_en_nxt = 4'h3;
        end
      end
      default: lane_en_nxt = 4'h1;
    endcase
  end
  assign nbytes = (width_r == `SMLM_DBW_32) ? 3'h4 : ((width_r == `SMLM_DBW_16) ? 3'h2 : 3'h1);
  assign req_ready_out = (state_r == ST_IDLE);
  // one timer for the read or write strobe, one for the chip select
  smlm_phase_timer u_strobe (
    .count_in(cnt_r),
    .setup_in(wr_r ? ws_r : rs_r),
    .pulse_in(wr_r ? wp_r : rp_r),
    .active_out(strobe_act),
    .last_out(strobe_last)
  );
  smlm_phase_timer u_cs (
    .count_in(cnt_r),
    .setup_in(ss_r),
    .pulse_in(sp_r),
    .active_out(cs_act),
    .last_out(cs_last)
  );
  // wait is honoured while the strobe pulse is low
  assign waiting = (state_r == ST_RUN) && strobe_act && !wait_request_n_in;
  assign cycle_end = (state_r == ST_RUN) && !waiting && (cnt_r + 6'h01 >= cyc_r);
  // read data sampled at the strobe's closing edge
  assign sample_rd = (state_r == ST_RUN) && !wr_r && !waiting && strobe_last;
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (req_valid_in) state_nxt = ST_RUN;
      ST_RUN: if (cycle_end) state_nxt = (beats_r != 6'h00) ? ST_NEXT : ST_IDLE;
      ST_NEXT: state_nxt = ST_RUN;
      default: state_nxt = ST_IDLE;
    endcase
  end
  assign cs_n_nxt = ~(8'h01 << cs_r);
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      cnt_r <= 6'h00;
      cs_r <= 3'h0;
      wr_r <= 1'b0;
      addr_r <= 26'h0000000;
      size_r <= 2'h0;
      beats_r <= 6'h00;
      wdata_r <= 32'h00000000;
      width_r <= `SMLM_BOOT_DBW;
      bat_r <= `SMLM_BOOT_BAT;
      rs_r <= 6'h00;
      rp_r <= 6'h01;
      cyc_r <= 6'h01;
      ss_r <= 6'h00;
      sp_r <= 6'h01;
      ws_r <= 6'h00;
      wp_r <= 6'h01;
      lane_en_r <= 4'h0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 32'h00000000;
      chip_select_n_out <= 8'hff;
      addr_out <= 24'h000000;
      data_out <= 32'h00000000;
      data_oe_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rsp_valid_out <= 1'b0;
      if (state_r == ST_IDLE && req_valid_in) begin
        cnt_r <= 6'h00;
        cs_r <= req_cs_in;
        wr_r <= req_write_in;
        addr_r <= req_addr_in;
        size_r <= req_size_in;
        // page burst of whole beats, up to 32 extra; a larger count gives a single beat
        beats_r <= req_write_in ? 6'h00 : ((req_burst_in > `SMLM_PAGE_MAX) ? 6'h00 : req_burst_in);
        wdata_r <= req_wdata_in;
        width_r <= req_width;
        bat_r <= req_bat;
        lane_en_r <= lane_en_nxt;
        if (slow_clock_in) begin
          // fixed slow-rate waveform replaces the programmed one
          rs_r <= `SMLM_SLOW_SETUP;
          rp_r <= `SMLM_SLOW_PULSE;
          ws_r <= `SMLM_SLOW_SETUP;
          wp_r <= `SMLM_SLOW_PULSE;
          ss_r <= 6'h00;
          sp_r <= `SMLM_SLOW_CYCLE;
          cyc_r <= `SMLM_SLOW_CYCLE;
        end else begin
          rs_r <= rd_setup_in[6*req_cs_in +: 6];
          rp_r <= rd_pulse_in[6*req_cs_in +: 6];
          ws_r <= wr_setup_in[6*req_cs_in +: 6];
          wp_r <= wr_pulse_in[6*req_cs_in +: 6];
          ss_r <= cs_setup_in[6*req_cs_in +: 6];
          sp_r <= cs_pulse_in[6*req_cs_in +: 6];
          cyc_r <= req_write_in ? wr_cycle_in[6*req_cs_in +: 6] : rd_cycle_in[6*req_cs_in +: 6];
        end
        // word-aligned upper address; low lines go through the shared pins
        addr_out <= req_addr_in[25:2];
      end else if (state_r == ST_RUN) begin
        if (!waiting) begin
          cnt_r <= cycle_end ? 6'h00 : cnt_r + 6'h01;
        end
      end else if (state_r == ST_NEXT) begin
        addr_r <= addr_r + {23'h000000, nbytes};
        addr_out <= addr_out_inc(addr_r, nbytes);
        beats_r <= beats_r - 6'h01;
      end
      // only once the new select and its timing are loaded, never the stale one
      chip_select_n_out <= ((state_r == ST_RUN) && cs_act) ? cs_n_nxt : 8'hff;
      if (state_r == ST_RUN && wr_r && cnt_r + 6'h01 == ws_r) begin
        data_out <= wdata_r;
        data_oe_out <= 1'b1;
      end else if (state_r == ST_RUN && wr_r && cnt_r == 6'h00 && ws_r == 6'h00) begin
        data_out <= wdata_r;
        data_oe_out <= 1'b1;
      end else if (cycle_end || state_r == ST_IDLE) begin
        data_oe_out <= 1'b0;
      end
      if (sample_rd) begin
        rsp_rdata_out <= data_in;
      end
      if (cycle_end) begin
        rsp_valid_out <= 1'b1;
      end
    end
  end
  function [23:0] addr_out_inc;
    input [25:0] a;
    input [2:0] n;
    reg [25:0] s;
    begin
      s = a + {23'h000000, n};
      addr_out_inc = s[25:2];
    end
  endfunction
  wire [1:0] addr_lo;
  wire strobe_rd;
  wire strobe_wr;
  wire pin_wr_n;
  assign addr_lo = addr_r[1:0];
  assign strobe_rd = (state_r == ST_RUN) && !wr_r && strobe_act;
  assign strobe_wr = (state_r == ST_RUN) && wr_r && strobe_act;
  smlm_lane_decode u_lanes (
    .width_in(width_r),
    .bat_in(bat_r),
    .lane_en_in(lane_en_r),
    .addr_lo_in(addr_lo),
    .addr_phase_in(state_r == ST_RUN),
    .rd_act_in(strobe_rd),
    .wr_act_in(strobe_wr),
    .pin0_out(lane0_select_n_out),
    .pin1_out(pin_wr_n),
    .pin2_out(lane2_select_n_out),
    .pin3_out(lane1_select_n_out),
    .pin4_out(lane3_select_n_out),
    .rd_n_out(read_strobe_n_out)
  );
  assign write_enable_n_out = pin_wr_n;
endmodule // smlm_mapper

// ===== dv/smlm_mapper_checker.sv
// Purpose: port-level checks for the lane mapper
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every smlm_mapper instance
module smlm_mapper_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic wait_request_n_in,
  input wire logic rsp_valid_out,
  input wire logic [7:0] chip_select_n_out,
  input wire logic [25:2] addr_out,
  input wire logic write_enable_n_out,
  input wire logic read_strobe_n_out,
  input wire logic [31:0] data_out,
  input wire logic data_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_RST_IDLE: assert property (disable iff (1'b0)
    rst_in |=> chip_select_n_out == 8'hff && !data_oe_out && req_ready_out)
    else $error("selects or data drive active after reset");
  AST_ONE_CS: assert property ($countones(~chip_select_n_out) <= 1)
    else $error("more than one chip select low");
  AST_CS_IDLE: assert property ($past(req_ready_out) |-> chip_select_n_out == 8'hff)
    else $error("chip select low without an access in progress");
  AST_OE_NO_RD: assert property (data_oe_out |-> read_strobe_n_out)
    else $error("data driven while read strobe low");
  AST_RD_NO_WR: assert property (!read_strobe_n_out |-> write_enable_n_out)
    else $error("write enable low during read");
  AST_TAKE_BUSY: assert property (req_valid_in && req_ready_out |=> !req_ready_out)
    else $error("ready stayed high after a request was taken");
  AST_WAIT_HOLD: assert property (
    !wait_request_n_in && !read_strobe_n_out |=> !rsp_valid_out)
    else $error("access completed while wait was asserted");
  AST_ADDR_STABLE: assert property (
    !read_strobe_n_out && !$past(read_strobe_n_out) |-> $stable(addr_out))
    else $error("address moved during read pulse");
  AST_RSP_BOUND: assert property (
    req_valid_in && req_ready_out |-> ##[1:300] rsp_valid_out)
    else $error("no response within bound");
  AST_OE_STABLE: assert property (
    data_oe_out && $past(data_oe_out) |-> $stable(data_out))
    else $error("write data changed while driven");
endmodule // smlm_mapper_checker

bind smlm_mapper smlm_mapper_checker smlm_mapper_checker_i (
  .clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
  .req_ready_out(req_ready_out), .wait_request_n_in(wait_request_n_in),
  .rsp_valid_out(rsp_valid_out), .chip_select_n_out(chip_select_n_out),
  .addr_out(addr_out), .write_enable_n_out(write_enable_n_out),
  .read_strobe_n_out(read_strobe_n_out), .data_out(data_out), .data_oe_out(data_oe_out));

// ===== dv/smlm_mem_model.sv
// Purpose: behavioural static memory on the far side of the mapper
// Assumes: read data answered while the read strobe is low
// Notes: data lines toggle outside read pulses so stale values never match
module smlm_mem_model (
  input wire logic clk_in,
  input wire logic read_strobe_n_in,
  input wire logic [25:2] addr_in,
  input wire logic [3:0] stall_in,
  output logic [31:0] data_out,
  output logic wait_request_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] noise_r = 32'h0;
  logic [3:0] stall_r = 4'h0;
  always @(posedge clk_in) begin
    noise_r <= ~noise_r;
    if (read_strobe_n_in) stall_r <= stall_in;
    else if (stall_r != 4'h0) stall_r <= stall_r - 4'h1;
  end
  assign wait_request_n_out = read_strobe_n_in || stall_r == 4'h0;
  assign data_out = read_strobe_n_in ? noise_r : {8'ha5, addr_in};
endmodule // smlm_mem_model

// ===== dv/smlm_mapper_tb_top.sv
// Purpose: directed bench for the lane mapper
// Assumes: all selects setup 1, pulse 2, cycle 4
// Notes: pins vector is {lane3, lane2, lane1, write_enable, lane0}, low = seen active
module smlm_mapper_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, slow = 1'b0;
  logic [2:0] req_cs = 3'h0;
  logic [25:0] req_addr = 26'h0;
  logic [1:0] req_size = 2'h0;
  logic [3:0] stall = 4'h0;
  logic [5:0] burst = 6'h00;
  logic [31:0] d_seen;
  logic [15:0] width = 16'h01a1;
  logic [7:0] byte_access_type = 8'h19;
  logic [47:0] su = {8{6'h01}}, pu = {8{6'h02}}, cy = {8{6'h04}}, zr = 48'h0;
  wire ready, rsp_valid, l0, we, l1, l2, l3, rd_n, oe, wait_n;
  wire [31:0] rdata, dout, din;
  wire [7:0] cs_n;
  wire [25:2] addr;
  int mismatches = 0, checks = 0, lat = 0, lat0 = 0;
  logic [4:0] pins;
  logic [7:0] cs_seen;
  logic [25:2] a_seen;
  // {write, select, address, size, mask, expected pins}
  logic [41:0] tbl [0:6] = '{
    {1'b1, 3'h3, 26'h0000100, 2'h2, 5'h1f, 5'h01}, {1'b1, 3'h3, 26'h0000102, 2'h0, 5'h1f, 5'h17},
    {1'b1, 3'h2, 26'h0000202, 2'h1, 5'h1f, 5'h05}, {1'b1, 3'h1, 26'h0000301, 2'h0, 5'h0b, 5'h01},
    {1'b1, 3'h4, 26'h0000403, 2'h0, 5'h0e, 5'h0a}, {1'b1, 3'h0, 26'h0000001, 2'h0, 5'h0f, 5'h01},
    {1'b0, 3'h2, 26'h3fffff0, 2'h2, 5'h1f, 5'h02}};
  always #2 clk = ~clk;
  smlm_mapper smlm_mapper_i (
    .clk_in(clk), .rst_in(rst), .req_valid_in(req_valid), .req_write_in(req_write),
    .req_cs_in(req_cs), .req_addr_in(req_addr), .req_size_in(req_size), .req_burst_in(burst),
    .req_wdata_in(32'h5a5a0f0f), .bus_width_field_in(width), .byte_access_type_in(byte_access_type),
    .rd_setup_in(su), .rd_pulse_in(pu), .rd_cycle_in(cy), .cs_setup_in(zr), .cs_pulse_in(cy),
    .wr_setup_in(su), .wr_pulse_in(pu), .wr_cycle_in(cy), .slow_clock_in(slow),
    .wait_request_n_in(wait_n), .data_in(din), .req_ready_out(ready), .rsp_valid_out(rsp_valid),
    .rsp_rdata_out(rdata), .chip_select_n_out(cs_n), .addr_out(addr), .lane0_select_n_out(l0),
    .write_enable_n_out(we), .lane1_select_n_out(l1), .lane2_select_n_out(l2),
    .lane3_select_n_out(l3), .read_strobe_n_out(rd_n), .data_out(dout), .data_oe_out(oe));
  smlm_mem_model smlm_mem_model_i (
    .clk_in(clk), .read_strobe_n_in(rd_n), .addr_in(addr), .stall_in(stall),
    .data_out(din), .wait_request_n_out(wait_n));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one access; pins accumulate every line seen low while a select is active
  task automatic access(input logic w, input logic [2:0] c, input logic [25:0] a,
      input logic [1:0] s);
    repeat (2) @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_cs = c;
    req_addr = a;
    req_size = s;
    @(negedge clk);
    req_valid = 1'b0;
    pins = 5'h1f;
    cs_seen = 8'hff;
    lat = 1;
    d_seen = 32'h0;
    while (rsp_valid !== 1'b1) begin
      if (oe === 1'b1) d_seen = dout;
      if (cs_n !== 8'hff) begin
        pins = pins & {l3, l2, l1, we, l0};
        cs_seen = cs_n;
        a_seen = addr;
      end
      @(negedge clk);
      lat++;
      if (lat > 200) begin
        mismatches++;
        summarize();
      end
    end
  endtask

  initial begin
    repeat (20) @(negedge clk);
    chk({24'h0, cs_n}, 32'h000000ff);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      access(tbl[i][41], tbl[i][40:38], tbl[i][37:12], tbl[i][11:10]);
      chk({27'h0, pins & tbl[i][9:5]}, {27'h0, tbl[i][4:0]});
      chk({24'h0, cs_seen}, {24'h0, ~(8'h01 << tbl[i][40:38])});
      chk({8'h0, a_seen}, {8'h0, tbl[i][37:14]});
      if (tbl[i][41]) chk(d_seen, 32'h5a5a0f0f);
    end
    chk(rdata, 32'ha5fffffc);
    lat0 = lat;
    stall = 4'h3;
    access(1'b0, 3'h2, 26'h0000020, 2'h2);
    chk({31'h0, lat > lat0}, 32'h1);
    chk(rdata, 32'ha5000008);
    stall = 4'h0;
    slow = 1'b1;
    access(1'b0, 3'h2, 26'h0000020, 2'h2);
    chk(lat, lat0 + 3);
    slow = 1'b0;
    // two-beat page read: the second beat steps the address by one word
    burst = 6'h01;
    access(1'b0, 3'h2, 26'h0000040, 2'h2);
    burst = 6'h00;
    chk(rdata, 32'ha5000010);
    @(negedge clk);
    for (lat = 0; lat < 50 && rsp_valid !== 1'b1; lat++) @(negedge clk);
    chk({31'h0, rsp_valid}, 32'h1);
    chk(rdata, 32'ha5000011);
    summarize();
  end
endmodule // smlm_mapper_tb_top
